// ==== rtl/dmapb_port.sv ====
// Peripheral byte bus master port of the transfer controller.
// Notes on behaviour
// - On reads raise strobe when ready; drop it on acknowledge or timer expiry.
// - On writes raise strobe only after data is driven; drop on acknowledge or timer.
// - Acknowledging slaves end accesses by acknowledge; others rely on the wait timer.
// - Drive a five-bit register address inside the selected peripheral.
// - Eight-bit two-way byte bus, driven on writes and sampled on reads.
// - Direction line is high for reads and low for writes.
// - Last-byte input is sampled in the cycle before the acknowledge.
// - Last-byte seen marks the read byte final for the owning channel.
// - Two equal 1X clocks, the first leading the second by a quarter period.
// - While float is asserted every output is released.
// - One of four selects picks the slave; dropping it ends the cycle.
// - Four asynchronous channel requests, single byte or burst per burst-length control.
module dmapb_port
(
    input  wire logic                           mclk,
    input  wire logic                           reset_n,
    input  wire logic                           cmd_valid,
    output logic                                cmd_ready,
    input  wire dmapb_pkg::dmapb_cmd_s          cmd,
    output logic                                rd_valid,
    input  wire logic                           rd_ready,
    output dmapb_pkg::dmapb_rdata_s             rd_data,
    output logic [dmapb_pkg::CHANS-1:0]         chan_request,
    input  wire logic                           float_all_outputs,
    output logic                                periph_ctrl_oe,
    output logic                                periph_data_strobe,
    output logic [dmapb_pkg::CHANS-1:0]         periph_slave_select,
    output logic [dmapb_pkg::ADDR_W-1:0]        periph_reg_addr,
    output logic                                periph_dir,
    input  wire logic [dmapb_pkg::BYTE_W-1:0]   periph_byte_in,
    output logic [dmapb_pkg::BYTE_W-1:0]        periph_byte_out,
    output logic                                periph_byte_oe,
    input  wire logic                           periph_xfer_ack,
    input  wire logic                           periph_last_byte,
    input  wire logic [dmapb_pkg::CHANS-1:0]    periph_channel_request
);
    import dmapb_pkg::*;

    localparam int TMR_BOUND = WAIT_CYCLES + 1;

    // ------------------------------------------------------------------
    // Reset release and input synchronisers
    // ------------------------------------------------------------------
    logic                rst_meta_r;
    logic                rst_n_r;
    logic [SYNC_W-1:0]   sync1_r;
    logic [SYNC_W-1:0]   sync2_r;
    wire  [SYNC_W-1:0]   async_in;
    wire                 ack_s;
    wire                 done_s;

    // The whole design runs on mclk, one of the two quadrature 1X phases.
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rst_meta_r <= 1'b0;
            rst_n_r    <= 1'b0;
        end
        else
        begin
            rst_meta_r <= 1'b1;
            rst_n_r    <= rst_meta_r;
        end
    end

    // Only the second stage is read, so metastability never reaches the state machine.
    assign async_in = {periph_channel_request, periph_last_byte, periph_xfer_ack};
    always_ff @(posedge mclk or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            sync1_r <= SYNC_RST;
            sync2_r <= SYNC_RST;
        end
        else
        begin
            sync1_r <= async_in;
            sync2_r <= sync1_r;
        end
    end

    assign ack_s        = sync2_r[0];
    assign done_s       = sync2_r[1];
    // Burst or single-byte service per request is the channel logic's decision.
    assign chan_request = sync2_r[SYNC_W-1:2];

    // ------------------------------------------------------------------
    // Access state machine
    // ------------------------------------------------------------------
    dmapb_state_e        state_r;
    dmapb_state_e        state_nxt;
    dmapb_cmd_s          cmd_r;
    logic [TMR_W-1:0]    tmr_r;
    logic                done_prev_r;
    logic [BYTE_W-1:0]   rbyte_r;
    logic                last_r;
    logic                strobe_r;
    logic [CHANS-1:0]    sel_r;
    logic                drive_r;
    wire                 accept;
    wire                 timer_done;
    wire                 term;
    wire                 fifo_in_ready;
    wire                 fifo_push;
    dmapb_rdata_s        fifo_wr;

    // A new access waits for the old acknowledge to clear and for buffer room.
    assign cmd_ready  = (state_r == ST_IDLE) && fifo_in_ready && !ack_s;
    assign accept     = cmd_valid && cmd_ready;
    assign timer_done = cmd_r.use_timer && (tmr_r == TMR_ZERO);
    assign term       = (state_r == ST_STROBE) && (ack_s || timer_done);
    assign fifo_push  = (state_r == ST_END) && cmd_r.rd;
    assign fifo_wr    = '{last: last_r, chan: cmd_r.chan, data: rbyte_r};

    // Next-state selection.
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE:   if (accept) state_nxt = ST_SETUP;
            ST_SETUP:  state_nxt = ST_STROBE;
            ST_STROBE: if (term) state_nxt = ST_END;
            ST_END:    state_nxt = ST_IDLE;
            default:   state_nxt = ST_IDLE;
        endcase
    end

    // State, command latch and wait timer.
    always_ff @(posedge mclk or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            state_r <= ST_IDLE;
            cmd_r   <= '0;
            tmr_r   <= TMR_ZERO;
        end
        else
        begin
            state_r <= state_nxt;
            if (accept)
                cmd_r <= cmd;
            if (state_r == ST_SETUP)
                tmr_r <= TMR_LOAD;
            else if (tmr_r != TMR_ZERO)
                tmr_r <= tmr_r - 1'b1;
        end
    end

    // Read capture; last-byte is taken from the cycle before the acknowledge is seen.
    always_ff @(posedge mclk or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            done_prev_r <= 1'b0;
            rbyte_r     <= BYTE_RST;
            last_r      <= 1'b0;
        end
        else
        begin
            done_prev_r <= done_s;
            if (term)
            begin
                rbyte_r <= periph_byte_in;
                last_r  <= cmd_r.rd && done_prev_r;
            end
        end
    end

    // Bus pins: select and address lead the strobe by one cycle, select trails it by one.
    always_ff @(posedge mclk or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            strobe_r <= 1'b0;
            sel_r    <= SEL_NONE;
            drive_r  <= 1'b0;
        end
        else
        begin
            if (state_r == ST_SETUP)
                strobe_r <= 1'b1;
            else if (term)
                strobe_r <= 1'b0;
            if (accept)
                sel_r <= SEL_ONE << cmd.chan;
            else if (state_r == ST_END)
                sel_r <= SEL_NONE;
            if (accept)
                drive_r <= !cmd.rd;
            else if (state_r == ST_END)
                drive_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------------
    // Float wins over everything, so a shared bus can be handed to a tester.
    assign periph_ctrl_oe      = !float_all_outputs;
    assign periph_byte_oe      = drive_r && !float_all_outputs;
    assign periph_data_strobe  = strobe_r;
    assign periph_slave_select = sel_r;
    assign periph_reg_addr     = cmd_r.addr;
    assign periph_dir          = cmd_r.rd ? DIR_READ : DIR_WRITE;
    assign periph_byte_out     = cmd_r.wdata;

    // ------------------------------------------------------------------
    // Read data buffer
    // ------------------------------------------------------------------
    dmapb_fifo #(.WIDTH(RDATA_W), .DEPTH(FIFO_DEPTH)) u_rd_fifo
    (
        .mclk      (mclk),
        .rst_n     (rst_n_r),
        .in_valid  (fifo_push),
        .in_ready  (fifo_in_ready),
        .in_data   (fifo_wr),
        .out_valid (rd_valid),
        .out_ready (rd_ready),
        .out_data  (rd_data)
    );

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    chk_strobe_ends: assert property (@(posedge mclk) disable iff (!rst_n_r)
        term |=> !periph_data_strobe) else $error("strobe not dropped after termination");
    chk_write_data_first: assert property (@(posedge mclk) disable iff (!rst_n_r)
        $rose(periph_data_strobe) && !cmd_r.rd |-> $past(drive_r) && $stable(periph_byte_out))
        else $error("write strobe rose before data was driven");
    chk_timer_bound: assert property (@(posedge mclk) disable iff (!rst_n_r)
        $rose(periph_data_strobe) && cmd_r.use_timer |-> ##[1:TMR_BOUND] !periph_data_strobe)
        else $error("wait timer did not end the strobe");
    chk_addr_steady: assert property (@(posedge mclk) disable iff (!rst_n_r)
        periph_data_strobe |-> $stable(periph_reg_addr) && $stable(periph_dir))
        else $error("address or direction moved under strobe");
    chk_dir_drive: assert property (@(posedge mclk) disable iff (!rst_n_r)
        periph_byte_oe |-> periph_dir == DIR_WRITE) else $error("byte bus driven during read");
    chk_last_sample: assert property (@(posedge mclk) disable iff (!rst_n_r)
        fifo_push |-> fifo_wr.last == $past(done_s, 2)) else $error("last-byte sample misaligned");
    chk_float_release: assert property (@(posedge mclk) disable iff (!rst_n_r)
        float_all_outputs |-> !periph_ctrl_oe && !periph_byte_oe) else $error("output driven while floated");
    chk_select_frames: assert property (@(posedge mclk) disable iff (!rst_n_r)
        periph_data_strobe |-> $onehot(periph_slave_select) ##1 (periph_slave_select != SEL_NONE))
        else $error("select not framing the strobe");
    chk_sync_delay: assert property (@(posedge mclk) disable iff (!rst_n_r)
        ##2 ack_s == $past(periph_xfer_ack, 2)) else $error("acknowledge synchroniser depth wrong");
endmodule // dmapb_port

// ==== rtl/dmapb_pkg.sv ====
// Shared constants, carrier structs and state codes of the peripheral bus port.
package dmapb_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 100;
    localparam int WAIT_TIME_NS  = 300;
    localparam int WAIT_CYCLES   = (WAIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TMR_W         = 4;
    localparam logic [TMR_W-1:0] TMR_LOAD = TMR_W'(WAIT_CYCLES - 1);
    localparam logic [TMR_W-1:0] TMR_ZERO = 4'h0;

    // ------------------------------------------------------------------
    // Widths and encodings
    // ------------------------------------------------------------------
    localparam int CHANS       = 4;
    localparam int CHAN_W      = 2;
    localparam int ADDR_W      = 5;
    localparam int BYTE_W      = 8;
    localparam int SYNC_W      = 6;
    localparam int FIFO_DEPTH  = 16;
    localparam logic DIR_READ  = 1'b1;
    localparam logic DIR_WRITE = 1'b0;
    localparam logic [CHANS-1:0]  SEL_NONE  = 4'h0;
    localparam logic [CHANS-1:0]  SEL_ONE   = 4'h1;
    localparam logic [ADDR_W-1:0] ADDR_RST  = 5'h00;
    localparam logic [BYTE_W-1:0] BYTE_RST  = 8'h00;
    localparam logic [SYNC_W-1:0] SYNC_RST  = 6'h00;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic              rd;
        logic              use_timer;
        logic [CHAN_W-1:0] chan;
        logic [ADDR_W-1:0] addr;
        logic [BYTE_W-1:0] wdata;
    } dmapb_cmd_s;

    typedef struct packed {
        logic              last;
        logic [CHAN_W-1:0] chan;
        logic [BYTE_W-1:0] data;
    } dmapb_rdata_s;

    localparam int RDATA_W = $bits(dmapb_rdata_s);

    typedef enum logic [3:0] {
        ST_IDLE   = 4'b0001,
        ST_SETUP  = 4'b0010,
        ST_STROBE = 4'b0100,
        ST_END    = 4'b1000
    } dmapb_state_e;

endpackage

// ==== rtl/dmapb_fifo.sv ====
// Parameterised first-in first-out buffer with valid and ready on both sides.
module dmapb_fifo
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
)
(
    input  wire logic             mclk,
    input  wire logic             rst_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW:0]      wptr_r;
    logic [AW:0]      rptr_r;
    wire              push;
    wire              pop;

    // ------------------------------------------------------------------
    // Flags
    // ------------------------------------------------------------------
    // The extra pointer bit tells full from empty without a counter.
    assign in_ready  = !((wptr_r[AW] != rptr_r[AW]) && (wptr_r[AW-1:0] == rptr_r[AW-1:0]));
    assign out_valid = (wptr_r != rptr_r);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem_r[rptr_r[AW-1:0]];

    // Storage carries no reset; only the pointers need a defined start.
    always_ff @(posedge mclk)
    begin
        if (push)
            mem_r[wptr_r[AW-1:0]] <= in_data;
    end

    // Pointers advance on each accepted push and pop.
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wptr_r <= '0;
            rptr_r <= '0;
        end
        else
        begin
            if (push)
                wptr_r <= wptr_r + 1'b1;
            if (pop)
                rptr_r <= rptr_r + 1'b1;
        end
    end
endmodule // dmapb_fifo

// ==== sim/dmapb_slave.sv ====
// Behavioural peripheral slave that answers the byte bus port.
module dmapb_slave
(
    input  wire logic                        mclk,
    input  wire logic [dmapb_pkg::CHANS-1:0] sel,
    input  wire logic                        stb,
    input  wire logic                        dir,
    input  wire logic [dmapb_pkg::ADDR_W-1:0] addr,
    input  wire logic                        byte_oe,
    input  wire logic [7:0]                  byte_wire,
    input  wire logic                        ack_en,
    input  wire logic [3:0]                  ack_dly,
    input  wire logic [7:0]                  rdata,
    input  wire logic                        last_en,
    output logic                             ack,
    output logic                             last,
    output logic [7:0]                       drv,
    output logic [7:0]                       wbyte,
    output logic                             wr_ok,
    output logic [4:0]                       addr_seen,
    output logic [3:0]                       stb_len
);
    timeunit 1ns;
    timeprecision 1ns;
    import dmapb_pkg::*;
    logic [3:0] cnt_r  = 4'h0;
    logic       stb_r  = 1'b0;
    logic [7:0] hold_r = 8'h00;
    // -----------------------------------------------------
    // Answer logic
    // -----------------------------------------------------
    // Only a selected slave answers; a released bus shows the inverse of the last byte.
    assign drv  = (sel != 4'h0 && dir && stb) ? rdata : ~hold_r;
    assign ack  = ack_en && stb && sel != 4'h0 && cnt_r >= ack_dly;
    assign last = last_en && dir && sel != 4'h0;
    // Strobe length and what the bus held as the strobe rose.
    always @(posedge mclk)
    begin
        hold_r <= drv;
        stb_r  <= stb;
        cnt_r  <= stb ? cnt_r + 4'h1 : 4'h0;
        if (stb && !stb_r)
        begin
            stb_len   <= 4'h1;
            wbyte     <= byte_wire;
            wr_ok     <= byte_oe;
            addr_seen <= addr;
        end
        else if (stb)
        begin
            stb_len <= stb_len + 4'h1;
        end
    end
endmodule // dmapb_slave

// ==== sim/dmapb_port_test.sv ====
// Self-checking bench of the peripheral byte bus port.
module dmapb_port_test;
    timeunit 1ns;
    timeprecision 1ns;
    import dmapb_pkg::*;
    logic mclk = 1'b0, reset_n = 1'b0, cmd_valid = 1'b0, rd_ready = 1'b0, flt = 1'b0;
    dmapb_cmd_s cmd = '0;
    logic cmd_ready, rd_valid, ctrl_oe, stb, dir, byte_oe, ack, last, ack_en = 1'b0, last_en = 1'b0, wr_ok;
    dmapb_rdata_s rd_data;
    logic [3:0] chan_request, sel, stb_len, ack_dly = 4'h1, req = 4'h0;
    logic [4:0] addr, addr_seen;
    logic [7:0] bout, drv, wbyte, rdata = 8'h00;
    wire  [7:0] byte_wire = byte_oe ? bout : drv;
    int failures = 0, comparisons = 0, cycles = 0;
    always #50 mclk = ~mclk;
    dmapb_port u_dut (.mclk(mclk), .reset_n(reset_n), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .cmd(cmd), .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data),
        .chan_request(chan_request), .float_all_outputs(flt), .periph_ctrl_oe(ctrl_oe),
        .periph_data_strobe(stb), .periph_slave_select(sel), .periph_reg_addr(addr),
        .periph_dir(dir), .periph_byte_in(byte_wire), .periph_byte_out(bout),
        .periph_byte_oe(byte_oe), .periph_xfer_ack(ack), .periph_last_byte(last),
        .periph_channel_request(req));
    dmapb_slave u_slave (.mclk(mclk), .sel(sel), .stb(stb), .dir(dir), .addr(addr), .byte_oe(byte_oe),
        .byte_wire(byte_wire), .ack_en(ack_en), .ack_dly(ack_dly), .rdata(rdata), .last_en(last_en),
        .ack(ack), .last(last), .drv(drv), .wbyte(wbyte), .wr_ok(wr_ok), .addr_seen(addr_seen),
        .stb_len(stb_len));
    // -----------------------------------------------------
    // Shared tasks
    // -----------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            failures++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        $display("comparisons=%0d failures=%0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // The command is held until a falling edge sees ready, so the next rising edge takes it.
    task automatic issue(input logic rd, input logic tmr, input logic [1:0] ch, input logic [4:0] ad,
                         input logic [7:0] wd);
        @(negedge mclk);
        cmd = '{rd: rd, use_timer: tmr, chan: ch, addr: ad, wdata: wd};
        cmd_valid = 1'b1;
        while (!cmd_ready) @(negedge mclk);
        @(negedge mclk);
        cmd_valid = 1'b0;
    endtask
    task automatic wait_stb();
        while (!stb) @(negedge mclk);
    endtask
    task automatic wait_done();
        repeat (2) @(negedge mclk);
        while (!cmd_ready) @(negedge mclk);
    endtask
    task automatic pop(input logic [10:0] exp);
        while (!rd_valid) @(negedge mclk);
        check(rd_data, exp);
        rd_ready = 1'b1;
        @(negedge mclk);
        rd_ready = 1'b0;
        // Ready rests low for a cycle, so a following pop never sets it in the same step.
        @(negedge mclk);
    endtask
    // -----------------------------------------------------
    // Scenarios
    // -----------------------------------------------------
    task automatic t_read_ack();
        ack_en = 1'b1; rdata = 8'hA5; last_en = 1'b0;
        issue(1'b1, 1'b0, 2'd2, 5'h13, 8'h00);
        wait_stb();
        check(dir, 1'b1);
        check(sel, 4'h4);
        check(addr, 5'h13);
        wait_done();
        check(addr_seen, 5'h13);
        pop({1'b0, 2'd2, 8'hA5});
        $display("test read_ack done");
    endtask
    task automatic t_read_timer();
        ack_en = 1'b0; rdata = 8'h5A; last_en = 1'b1;
        issue(1'b1, 1'b1, 2'd1, 5'h1F, 8'h00);
        wait_done();
        check(stb_len, WAIT_CYCLES);
        pop({1'b1, 2'd1, 8'h5A});
        last_en = 1'b0;
        $display("test read_timer done");
    endtask
    task automatic t_write();
        ack_en = 1'b1; ack_dly = 4'h2;
        issue(1'b0, 1'b0, 2'd3, 5'h00, 8'h3C);
        wait_stb();
        check(dir, 1'b0);
        check(byte_oe, 1'b1);
        check(sel, 4'h8);
        wait_done();
        check(wbyte, 8'h3C);
        check(wr_ok, 1'b1);
        check(sel, 4'h0);
        $display("test write done");
    endtask
    task automatic t_float();
        issue(1'b0, 1'b1, 2'd0, 5'h01, 8'hC3);
        wait_stb();
        flt = 1'b1;
        #1 check({ctrl_oe, byte_oe}, 2'b00);
        @(negedge mclk);
        flt = 1'b0;
        #1 check({ctrl_oe, byte_oe}, 2'b11);
        wait_done();
        $display("test float done");
    endtask
    task automatic t_request();
        @(negedge mclk);
        req = 4'hA;
        @(negedge mclk);
        check(chan_request, 4'h0);
        @(negedge mclk);
        check(chan_request, 4'hA);
        req = 4'h0;
        $display("test request done");
    endtask
    // The consumer stalls while sixteen reads fill the buffer, then drains it in order.
    task automatic t_fill();
        ack_en = 1'b1; ack_dly = 4'h0;
        for (int i = 0; i < FIFO_DEPTH; i++)
        begin
            rdata = 8'(i * 17);
            issue(1'b1, 1'b0, 2'(i), 5'(i), 8'h00);
            // The byte is captured as the strobe ends, so the next value waits until then.
            wait_stb();
            while (stb) @(negedge mclk);
        end
        repeat (12) @(negedge mclk);
        check(cmd_ready, 1'b0);
        for (int i = 0; i < FIFO_DEPTH; i++)
            pop({1'b0, 2'(i), 8'(i * 17)});
        @(negedge mclk);
        check(rd_valid, 1'b0);
        $display("test fill done");
    endtask
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 6000)
        begin
            failures++;
            final_report();
        end
    end
    initial
    begin
        repeat (20) @(negedge mclk);
        check({stb, sel, byte_oe, rd_valid}, 7'h00);
        reset_n = 1'b1;
        repeat (3) @(negedge mclk);
        t_read_ack();
        t_read_timer();
        t_write();
        t_float();
        t_request();
        t_fill();
        final_report();
    end
endmodule // dmapb_port_test
